// [core/sbs_regs.svh]
// Constants shared by both ends of the synchronous burst SRAM link.
// Included by the package and the modules; holds definitions only.
`ifndef SBS_REGS_SVH
`define SBS_REGS_SVH

// ----------------------------------------------------------------
// Array geometry
// ----------------------------------------------------------------
`define SBS_ADDR_W 17
`define SBS_DATA_W 36
`define SBS_DEPTH 131072
`define SBS_LANES 4
`define SBS_BEATS 4

// ----------------------------------------------------------------
// Controller register offsets (byte addresses)
// ----------------------------------------------------------------
`define SBS_OFS_CTRL 8'h00
`define SBS_OFS_ADDR 8'h04
`define SBS_OFS_STAT 8'h08
`define SBS_OFS_DATA 8'h10
`define SBS_OFS_PAR 8'h20

// ----------------------------------------------------------------
// Control and status fields
// ----------------------------------------------------------------
`define SBS_CTRL_START 0
`define SBS_CTRL_WRITE 1
`define SBS_CTRL_BURST 2
`define SBS_CTRL_ORDER 3
`define SBS_CTRL_LANE_LO 4
`define SBS_CTRL_OE_OFF 8
`define SBS_CTRL_RESET 9'h0F0
`define SBS_STAT_BUSY 0
`define SBS_STAT_DONE 1

`endif

// [core/sbs_pkg.sv]
// Types shared by both ends of the synchronous burst SRAM link.
// Assumes sbs_regs.svh is on the include path.
`include "sbs_regs.svh"

package sbs_pkg;
    typedef logic [`SBS_ADDR_W-1:0] sbs_addr_t;
    typedef logic [`SBS_DATA_W-1:0] sbs_word_t;
    typedef logic [`SBS_LANES-1:0] sbs_lanes_t;
    typedef enum logic [1:0] {
        SBS_IDLE,
        SBS_LOAD,
        SBS_BURST,
        SBS_DRAIN
    } sbs_ctl_state_e;
endpackage

// [core/sbs_if.sv]
// Pin bundle between the memory controller and the burst SRAM.
// Assumes both ends run on one clock supplied by the bench.
`timescale 1ns/1ns

interface sbs_if;
    import sbs_pkg::*;
    sbs_addr_t address_pins;
    logic read_write_sel;
    logic advance_load;
    logic chip_select_a_n;
    logic chip_select_b_n;
    logic chip_select_high;
    logic burst_order_sel;
    logic clock_gate_n;
    sbs_lanes_t byte_lane_write_n;
    logic output_enable_n;
    sbs_word_t ctl_data;
    logic ctl_data_oe;
    sbs_word_t dev_data;
    logic dev_data_oe;
    sbs_word_t data_bus;

    // Shared data pins: low 32 bits are data_pins, top 4 are parity_pins;
    // kept as a mux, so an idle bus shows the controller's last word
    assign data_bus = dev_data_oe ? dev_data : ctl_data;

    modport dev (
        input address_pins, read_write_sel, advance_load, chip_select_a_n,
        input chip_select_b_n, chip_select_high, burst_order_sel, clock_gate_n,
        input byte_lane_write_n, output_enable_n, data_bus,
        output dev_data, dev_data_oe
    );
    modport ctl (
        output address_pins, read_write_sel, advance_load, chip_select_a_n,
        output chip_select_b_n, chip_select_high, burst_order_sel, clock_gate_n,
        output byte_lane_write_n, output_enable_n, ctl_data, ctl_data_oe,
        input data_bus
    );
endinterface // sbs_if

// [core/sbs_sram_dev.sv]
// Burst SRAM end: 128K x 36 array, command pipeline and flow-through read.
// Assumes the controller drives the pins from the same clock_i.
//
// Notes on behaviour
// - Each 9-bit lane has own low write enable
// - Controller drives lane enables on load writes
// - Controller drives lane enables every burst beat
// - Lane enables ignored when read_write_sel high
// - Lanes written from data one clock later
// - Controller may tie all lane enables low
// - Any false chip select with load deselects
// - Bus floats one clock after deselect
// - Three chip selects must all be true
// - Rising edge only; output enable asynchronous
// - Write data captured in input register
// - Read data flows combinationally from array
// - Order select high gives interleaved burst
// - Order select low gives linear burst
// - Output enable high floats the data pins
// - Controller may hold output enable low
// - Load takes address; advance steps counter
// - Clock gate high freezes every register
// - Data transfer one clock after command
// - Low two bits cycle four beats, wrap
`timescale 1ns/1ns
`include "sbs_regs.svh"

module sbs_sram_dev
    import sbs_pkg::*;
(
    input wire logic clock_i, // 100 MHz clock
    input wire logic rst_b_i, // Async reset, active low
    sbs_if.dev pins, // Memory pins
    output logic burst_active_o, // A burst is loaded
    output logic data_phase_o // Data transfer in this cycle
);

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------

    // Low address bits of a beat; wraps after four beats
    function automatic logic [1:0] burst_low(input logic [1:0] start,
                                             input logic [1:0] cnt,
                                             input logic interleave);
        burst_low = interleave ? (start ^ cnt) : 2'(start + cnt);
    endfunction

    // Replace only lanes whose low enable is asserted
    function automatic sbs_word_t lane_merge(input sbs_word_t old_word,
                                             input sbs_word_t new_word,
                                             input sbs_lanes_t lanes_n);
        sbs_word_t res;
        res = old_word;
        for (int i = 0; i < `SBS_LANES; i++) begin
            if (!lanes_n[i]) begin
                res[8*i +: 8] = new_word[8*i +: 8];
                res[32+i] = new_word[32+i];
            end
        end
        lane_merge = res;
    endfunction

    // ----------------------------------------------------------------
    // Storage and state
    // ----------------------------------------------------------------
    sbs_word_t mem [0:`SBS_DEPTH-1];

    logic selected;
    logic step;
    logic burst_on;
    logic burst_wr;
    sbs_addr_t base_addr;
    logic [1:0] beat_cnt;
    logic [1:0] next_beat;
    sbs_addr_t next_burst_addr;
    logic xfer_on;
    logic xfer_wr;
    sbs_addr_t xfer_addr;
    sbs_lanes_t xfer_lanes_n;
    logic wr_pend;
    sbs_addr_t wr_addr;
    sbs_lanes_t wr_lanes_n;
    sbs_word_t din;
    sbs_word_t rd_raw;

    // Selected only when all three selects are true
    assign selected = !pins.chip_select_a_n && !pins.chip_select_b_n
                      && pins.chip_select_high;

    // Edge is swallowed while the gate is high
    assign step = !pins.clock_gate_n;

    // Next beat keeps the loaded upper bits
    assign next_beat = beat_cnt + 2'h1;
    assign next_burst_addr = {base_addr[`SBS_ADDR_W-1:2],
                              burst_low(base_addr[1:0], next_beat,
                                        pins.burst_order_sel)};

    // ----------------------------------------------------------------
    // Command stage
    // ----------------------------------------------------------------

    // Load or deselect on advance_load low, else count the burst
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            burst_on <= 1'b0;
            burst_wr <= 1'b0;
            base_addr <= '0;
            beat_cnt <= 2'h0;
        end else if (step) begin
            if (!pins.advance_load) begin
                burst_on <= selected;
                beat_cnt <= 2'h0;
                if (selected) begin
                    base_addr <= pins.address_pins;
                    burst_wr <= !pins.read_write_sel;
                end
            end else if (burst_on) begin
                beat_cnt <= next_beat;
            end
        end
    end

    // ----------------------------------------------------------------
    // Data stage: the transfer one clock after its command
    // ----------------------------------------------------------------

    // A deselect empties this stage, which floats the bus next cycle
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            xfer_on <= 1'b0;
            xfer_wr <= 1'b0;
            xfer_addr <= '0;
            xfer_lanes_n <= '1;
        end else if (step) begin
            if (!pins.advance_load) begin
                xfer_on <= selected;
                xfer_wr <= !pins.read_write_sel;
                xfer_addr <= pins.address_pins;
                // Reads never write, whatever the lane enables say
                xfer_lanes_n <= pins.read_write_sel ? '1
                                : pins.byte_lane_write_n;
            end else begin
                // Burst direction was fixed at load time
                xfer_on <= burst_on;
                xfer_wr <= burst_wr;
                xfer_addr <= next_burst_addr;
                xfer_lanes_n <= burst_wr ? pins.byte_lane_write_n : '1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Write path
    // ----------------------------------------------------------------

    // Input register takes the bus in the data cycle of a write
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wr_pend <= 1'b0;
            wr_addr <= '0;
            wr_lanes_n <= '1;
            din <= '0;
        end else if (step) begin
            wr_pend <= xfer_on && xfer_wr;
            if (xfer_on && xfer_wr) begin
                din <= pins.data_bus;
                wr_addr <= xfer_addr;
                wr_lanes_n <= xfer_lanes_n;
            end
        end
    end

    // Late write from the input register; timing is eased at the cost
    // of the bypass below
    always_ff @(posedge clock_i) begin
        if (step && wr_pend) begin
            mem[wr_addr] <= lane_merge(mem[wr_addr], din, wr_lanes_n);
        end
    end

    // ----------------------------------------------------------------
    // Read path
    // ----------------------------------------------------------------

    // No output register; a write still waiting in din is forwarded
    always_comb begin
        rd_raw = mem[xfer_addr];
        if (wr_pend && (wr_addr == xfer_addr)) begin
            rd_raw = lane_merge(rd_raw, din, wr_lanes_n);
        end
    end

    assign pins.dev_data = rd_raw;

    // Drive only in a read data cycle with the async enable low
    assign pins.dev_data_oe = xfer_on && !xfer_wr
                              && !pins.output_enable_n;

    // ----------------------------------------------------------------
    // Status
    // ----------------------------------------------------------------
    assign burst_active_o = burst_on;
    assign data_phase_o = xfer_on;

endmodule // sbs_sram_dev

// [core/sbs_sram_ctrl.sv]
// Memory controller end: Wishbone classic slave that runs single or
// four-beat SRAM transfers. Assumes the SRAM shares clock_i.
`timescale 1ns/1ns
`include "sbs_regs.svh"

module sbs_sram_ctrl
    import sbs_pkg::*;
(
    input wire logic clock_i, // 100 MHz clock
    input wire logic rst_b_i, // Async reset, active low
    input wire logic wb_cyc_i, // Bus cycle
    input wire logic wb_stb_i, // Strobe
    input wire logic wb_we_i, // Write
    input wire logic [7:0] wb_adr_i, // Byte address
    input wire logic [3:0] wb_sel_i, // Byte selects
    input wire logic [31:0] wb_dat_i, // Write data
    output logic [31:0] wb_dat_o, // Read data
    output logic wb_ack_o, // Acknowledge
    sbs_if.ctl pins // Memory pins
);

    // Byte-select merge for register writes
    function automatic logic [31:0] apply_sel(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0] sel);
        for (int i = 0; i < 4; i++) begin
            old_v[8*i +: 8] = sel[i] ? new_v[8*i +: 8] : old_v[8*i +: 8];
        end
        apply_sel = old_v;
    endfunction

    sbs_ctl_state_e state;
    logic [8:0] ctrl;
    sbs_addr_t addr;
    logic done;
    logic [1:0] beat;
    logic dph_on;
    logic dph_wr;
    logic [1:0] dph_beat;
    sbs_word_t wbuf [0:`SBS_BEATS-1];
    sbs_word_t rbuf [0:`SBS_BEATS-1];
    logic wb_req;
    logic wb_wr;
    logic start;
    logic issue;
    logic [31:0] ctrl_w;
    logic [31:0] addr_w;

    // ----------------------------------------------------------------
    // Wishbone slave
    // ----------------------------------------------------------------
    assign wb_req = wb_cyc_i && wb_stb_i;
    // Writes land on the edge where the master sees ack
    assign wb_wr = wb_req && wb_we_i && wb_ack_o;
    assign start = wb_wr && (wb_adr_i == `SBS_OFS_CTRL) && wb_sel_i[0]
                   && wb_dat_i[`SBS_CTRL_START] && (state == SBS_IDLE);
    assign ctrl_w = apply_sel({23'h0, ctrl}, wb_dat_i, wb_sel_i);
    assign addr_w = apply_sel({15'h0, addr}, wb_dat_i, wb_sel_i);

    // Ack one cycle after the request, dropped the cycle after
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end else begin
            wb_ack_o <= wb_req && !wb_ack_o;
            if (wb_req && !wb_ack_o) begin
                wb_dat_o <= 32'h0; // Unmapped reads give zero
                if (wb_adr_i == `SBS_OFS_CTRL) begin
                    wb_dat_o <= {23'h0, ctrl & 9'h1FE};
                end else if (wb_adr_i == `SBS_OFS_ADDR) begin
                    wb_dat_o <= {15'h0, addr};
                end else if (wb_adr_i == `SBS_OFS_STAT) begin
                    wb_dat_o <= {30'h0, done, state != SBS_IDLE};
                end else if (wb_adr_i[7:4] == 4'h1) begin
                    wb_dat_o <= rbuf[wb_adr_i[3:2]][31:0];
                end else if (wb_adr_i[7:4] == 4'h2) begin
                    wb_dat_o <= {28'h0, rbuf[wb_adr_i[3:2]][35:32]};
                end
            end
        end
    end

    // Control, address, done flag and write buffer
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ctrl <= `SBS_CTRL_RESET;
            addr <= '0;
            done <= 1'b0;
            for (int i = 0; i < `SBS_BEATS; i++) begin
                wbuf[i] <= '0;
            end
        end else begin
            if (wb_wr && (wb_adr_i == `SBS_OFS_CTRL)) begin
                ctrl <= ctrl_w[8:0];
            end
            if (wb_wr && (wb_adr_i == `SBS_OFS_ADDR)) begin
                addr <= addr_w[`SBS_ADDR_W-1:0];
            end
            if (wb_wr && (wb_adr_i[7:4] == 4'h1)) begin
                wbuf[wb_adr_i[3:2]][31:0] <=
                    apply_sel(wbuf[wb_adr_i[3:2]][31:0], wb_dat_i, wb_sel_i);
            end
            if (wb_wr && (wb_adr_i[7:4] == 4'h2) && wb_sel_i[0]) begin
                wbuf[wb_adr_i[3:2]][35:32] <= wb_dat_i[3:0];
            end
            // Completion beats a same-cycle write-one clear
            if (state == SBS_DRAIN) begin
                done <= 1'b1;
            end else if (wb_wr && (wb_adr_i == `SBS_OFS_STAT) && wb_sel_i[0]
                         && wb_dat_i[`SBS_STAT_DONE]) begin
                done <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Transfer sequencer
    // ----------------------------------------------------------------
    assign issue = (state == SBS_LOAD) || (state == SBS_BURST);

    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state <= SBS_IDLE;
            beat <= 2'h0;
        end else begin
            case (state)
                SBS_IDLE: begin
                    beat <= 2'h0;
                    if (start) begin
                        state <= SBS_LOAD;
                    end
                end
                SBS_LOAD: begin
                    beat <= 2'h1;
                    state <= ctrl[`SBS_CTRL_BURST] ? SBS_BURST : SBS_DRAIN;
                end
                SBS_BURST: begin
                    beat <= beat + 2'h1;
                    if (beat == 2'h3) begin
                        state <= SBS_DRAIN;
                    end
                end
                SBS_DRAIN: state <= SBS_IDLE;
                default: state <= SBS_IDLE;
            endcase
        end
    end

    // Data phase one clock behind each issued beat
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            dph_on <= 1'b0;
            dph_wr <= 1'b0;
            dph_beat <= 2'h0;
            pins.ctl_data <= '0;
            for (int i = 0; i < `SBS_BEATS; i++) begin
                rbuf[i] <= '0;
            end
        end else begin
            dph_on <= issue;
            dph_wr <= ctrl[`SBS_CTRL_WRITE];
            dph_beat <= beat;
            if (issue) begin
                pins.ctl_data <= wbuf[beat];
            end
            if (dph_on && !dph_wr) begin
                rbuf[dph_beat] <= pins.data_bus;
            end
        end
    end

    // ----------------------------------------------------------------
    // Pin drive
    // ----------------------------------------------------------------
    assign pins.ctl_data_oe = dph_on && dph_wr;
    // Idle and drain cycles deselect with a load
    assign pins.advance_load = (state == SBS_BURST);
    assign pins.chip_select_a_n = !issue;
    assign pins.chip_select_b_n = 1'b0;
    assign pins.chip_select_high = 1'b1;
    assign pins.read_write_sel = !ctrl[`SBS_CTRL_WRITE];
    assign pins.address_pins = addr;
    // Lane enables held valid on load and every burst beat
    assign pins.byte_lane_write_n = ~ctrl[`SBS_CTRL_LANE_LO +: `SBS_LANES];
    assign pins.burst_order_sel = ctrl[`SBS_CTRL_ORDER];
    assign pins.clock_gate_n = 1'b0; // Never suspends
    assign pins.output_enable_n = ctrl[`SBS_CTRL_OE_OFF];

endmodule // sbs_sram_ctrl

// [testbench/sbs_asserts.sv]
// Checker for the pin bundle between the controller and the burst SRAM.
// Assumes it sits beside the interface and shares clock_i with both ends.
`timescale 1ns/1ns

module sbs_asserts
    import sbs_pkg::*;
(
    input wire logic clock_i, // Clock
    input wire logic rst_b_i, // Reset, active low
    input wire logic read_write_sel, // High reads
    input wire logic advance_load, // Low loads
    input wire logic chip_select_a_n, // Select a, low
    input wire logic chip_select_b_n, // Select b, low
    input wire logic chip_select_high, // Select, high
    input wire logic burst_order_sel, // Burst order
    input wire logic clock_gate_n, // Edge suspend
    input wire logic output_enable_n, // Output enable, low
    input wire logic ctl_data_oe, // Controller drives
    input wire logic dev_data_oe // Device drives
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_b_i);

    // ------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------
    logic sel_ok;
    logic load_cmd;
    logic desel_cmd;
    assign sel_ok = !chip_select_a_n && !chip_select_b_n && chip_select_high;
    assign load_cmd = !clock_gate_n && !advance_load && sel_ok;
    assign desel_cmd = !clock_gate_n && !advance_load && !sel_ok;

    // ------------------------------------------------------------
    // Data phase timing
    // ------------------------------------------------------------
    a_read_answer: assert property (load_cmd && read_write_sel |=> output_enable_n || dev_data_oe)
        else $error("no read data after load read");
    a_read_beat: assert property (load_cmd && read_write_sel ##1 (advance_load && !clock_gate_n)
        |=> output_enable_n || dev_data_oe)
        else $error("no read data after advance");
    a_write_phase: assert property (load_cmd && !read_write_sel |=> ctl_data_oe && !dev_data_oe)
        else $error("write data phase wrong");
    a_desel_float: assert property (desel_cmd |=> !dev_data_oe)
        else $error("bus driven after deselect");
    a_desel_idle: assert property (desel_cmd |=> !dev_data_oe && !ctl_data_oe)
        else $error("transfer after deselect");
    a_oe_float: assert property (output_enable_n |-> !dev_data_oe)
        else $error("bus driven with output enable high");
    a_no_clash: assert property (!(dev_data_oe && ctl_data_oe))
        else $error("both ends drive the bus");
    a_order_static: assert property (advance_load |-> $stable(burst_order_sel))
        else $error("burst order changed in burst");

    // Main scenarios reached
    c_read_burst: cover property (load_cmd && read_write_sel ##1 advance_load [*3]);
    c_write_load: cover property (load_cmd && !read_write_sel);
    c_oe_off_read: cover property (load_cmd && read_write_sel && output_enable_n);
endmodule // sbs_asserts

// [testbench/sync_burst_sram_pin_control_tb_top.sv]
// Self-checking bench: Wishbone orders to the controller, SRAM end behind it.
// Assumes the core files are compiled first and sbs_regs.svh is on the path.
`timescale 1ns/1ns
`include "sbs_regs.svh"

module sync_burst_sram_pin_control_tb_top;
    import sbs_pkg::*;
    logic clock_i;
    logic rst_b_i;
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
    logic [31:0] dat_o;
    logic ack;
    logic ph_o;
    logic act_o;
    int ph_cnt;
    int err_total;
    int num_checks;
    int cyc_cnt;
    int dev_cnt;
    int beat_cnt;
    sbs_word_t mem [sbs_addr_t];

    sbs_if i_sbs_if ();
    sbs_sram_ctrl i_sbs_sram_ctrl (.clock_i(clock_i), .rst_b_i(rst_b_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
        .wb_dat_o(dat_o), .wb_ack_o(ack), .pins(i_sbs_if));
    sbs_sram_dev i_sbs_sram_dev (.clock_i(clock_i), .rst_b_i(rst_b_i), .pins(i_sbs_if),
        .burst_active_o(act_o), .data_phase_o(ph_o));
    sbs_asserts i_sbs_asserts (.clock_i(clock_i), .rst_b_i(rst_b_i),
        .read_write_sel(i_sbs_if.read_write_sel), .advance_load(i_sbs_if.advance_load),
        .chip_select_a_n(i_sbs_if.chip_select_a_n), .chip_select_b_n(i_sbs_if.chip_select_b_n),
        .chip_select_high(i_sbs_if.chip_select_high), .burst_order_sel(i_sbs_if.burst_order_sel),
        .clock_gate_n(i_sbs_if.clock_gate_n), .output_enable_n(i_sbs_if.output_enable_n),
        .ctl_data_oe(i_sbs_if.ctl_data_oe), .dev_data_oe(i_sbs_if.dev_data_oe));

    // ------------------------------------------------------------
    // Clock, bus activity counters and hang guard
    // ------------------------------------------------------------
    initial begin
        clock_i = 1'b0;
        forever #5 clock_i = ~clock_i;
    end
    // Counting driven cycles shows framing without knowing controller latency
    always @(posedge clock_i) begin
        cyc_cnt++;
        dev_cnt += int'(i_sbs_if.dev_data_oe === 1'b1);
        beat_cnt += int'(i_sbs_if.dev_data_oe === 1'b1 || i_sbs_if.ctl_data_oe === 1'b1);
        ph_cnt += int'(ph_o === 1'b1) + int'(act_o === 1'b1);
        if (cyc_cnt == 20000) begin
            err_total++;
            give_verdict();
        end
    end

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic check(input logic [35:0] seen, input logic [35:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // Classic cycle: hold until ack is sampled, then release
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] q);
        int n;
        @(posedge clock_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        n = 0;
        do begin
            @(posedge clock_i);
            n++;
        end while (ack !== 1'b1 && n < 100);
        if (n >= 100) err_total++;
        q = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    function automatic sbs_word_t pat(input sbs_addr_t a);
        return {a[3:0], a[15:0], ~a[15:0]};
    endfunction
    // One SRAM transfer: fill buffers, start, await done, judge beats
    task automatic xfer(input logic w, b, o, input logic [3:0] ln, input sbs_addr_t a,
        input logic off);
        sbs_addr_t ak;
        sbs_word_t v;
        sbs_word_t m;
        logic [31:0] q;
        logic [31:0] p;
        int n;
        int d0;
        int b0;
        int p0;
        n = b ? 4 : 1;
        for (int k = 0; k < n; k++) begin
            ak = {a[16:2], o ? a[1:0] ^ 2'(k) : a[1:0] + 2'(k)};
            v = pat(ak) ^ {36{ln != 4'hF}};
            m = mem.exists(ak) ? mem[ak] : '0;
            for (int i = 0; i < 4; i++) begin
                if (ln[i] && w) begin
                    m[8*i+:8] = v[8*i+:8];
                    m[32+i] = v[32+i];
                end
            end
            mem[ak] = m;
            bus(1'b1, 8'h10 + 8'(4*k), v[31:0], q);
            bus(1'b1, 8'h20 + 8'(4*k), {28'h0, v[35:32]}, q);
        end
        d0 = dev_cnt;
        b0 = beat_cnt;
        p0 = ph_cnt;
        bus(1'b1, `SBS_OFS_ADDR, {15'h0, a}, q);
        bus(1'b1, `SBS_OFS_CTRL, {23'h0, off, ln, o, b, w, 1'b1}, q);
        q = 0;
        for (int t = 0; t < 50 && q[1] !== 1'b1; t++) bus(1'b0, `SBS_OFS_STAT, 0, q);
        check({35'h0, q[1]}, 36'h1);
        bus(1'b1, `SBS_OFS_STAT, 32'h0000_0002, q);
        check(36'(ph_cnt - p0), 2 * n);
        check(36'(beat_cnt - b0), (off && !w) ? 0 : n);
        check(36'(dev_cnt - d0), (off || w) ? 0 : n);
        for (int k = 0; k < n && !w && !off; k++) begin
            ak = {a[16:2], o ? a[1:0] ^ 2'(k) : a[1:0] + 2'(k)};
            bus(1'b0, 8'h10 + 8'(4*k), 0, q);
            bus(1'b0, 8'h20 + 8'(4*k), 0, p);
            check({p[3:0], q}, mem[ak]);
        end
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    // Unmapped place: write dropped, read gives zero
    task automatic t_unmapped();
        logic [31:0] q;
        bus(1'b1, 8'h3C, 32'hFFFF_FFFF, q);
        bus(1'b0, 8'h3C, 0, q);
        check({4'h0, q}, 0);
    endtask
    // Full burst, partial-lane burst, lane-ignoring read, single ops
    task automatic t_lanes();
        xfer(1'b1, 1'b1, 1'b0, 4'hF, 17'h12344, 1'b0);
        xfer(1'b1, 1'b1, 1'b1, 4'h5, 17'h12346, 1'b0);
        xfer(1'b0, 1'b1, 1'b0, 4'h0, 17'h12345, 1'b0);
        xfer(1'b1, 1'b0, 1'b0, 4'hA, 17'h12347, 1'b0);
        xfer(1'b0, 1'b0, 1'b0, 4'hF, 17'h12347, 1'b0);
    endtask
    // Every start value in both burst orders, upper bits held
    task automatic t_order();
        for (int o = 0; o < 2; o++) begin
            for (int s = 0; s < 4; s++) begin
                xfer(1'b0, 1'b1, 1'(o), 4'hF, 17'h12344 | 17'(s), 1'b0);
            end
        end
    endtask
    // Output enable off: device must keep off the bus; then a single read with it on
    task automatic t_oe_off();
        xfer(1'b0, 1'b1, 1'b0, 4'hF, 17'h12344, 1'b1);
        xfer(1'b0, 1'b0, 1'b1, 4'hF, 17'h12346, 1'b0);
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        rst_b_i = 1'b0;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 8'h00;
        sel = 4'hF;
        dat = 32'h0000_0000;
        err_total = 0;
        num_checks = 0;
        cyc_cnt = 0;
        dev_cnt = 0;
        beat_cnt = 0;
        ph_cnt = 0;
        repeat (20) @(posedge clock_i);
        rst_b_i <= 1'b1;
        t_unmapped();
        t_lanes();
        t_order();
        t_oe_off();
        give_verdict();
    end
endmodule // sync_burst_sram_pin_control_tb_top
